// ### design/dcc_map.svh
// dcc_map.svh: offsets, field positions, reset values and counts of the dual oscillator
// clock control. Included by the package-using design; holds definitions only.
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// register offsets on the plain register port
`define DCC_ADDR_CTRL       4'h0
`define DCC_ADDR_MASK_OPTION_STATUS       4'h1

// clock_select_and_status field positions
`define DCC_BIT_FAST_RDY    7
`define DCC_BIT_SLOW_RDY    6
`define DCC_BIT_SEL_HI      3
`define DCC_BIT_SEL_LO      2
`define DCC_BIT_FOSC_EN     1
`define DCC_BIT_OPT_MAP     0

// preset value shared by the fast chain and the power-on divider
`define DCC_PRESET_FAST     13'h0078
`define DCC_PRESET_POD      14'h0078

// lcd taps on the power-on divider
`define DCC_LCD64_MASK      14'h003F
`define DCC_LCD128_MASK     14'h007F

`endif

// ### design/dcc_pkg.sv
// dcc_pkg: types of the dual oscillator clock control.
// Assumes dcc_map.svh supplies the numeric constants.
package dcc_pkg;

   typedef enum logic [1:0] {
      DCC_RUN  = 2'b00,
      DCC_WAIT = 2'b01,
      DCC_STOP = 2'b10
   } dcc_mode_t;

   typedef enum logic [1:0] {
      DCC_SEL_FAST2  = 2'b00,
      DCC_SEL_FAST4  = 2'b01,
      DCC_SEL_FAST64 = 2'b10,
      DCC_SEL_SLOW2  = 2'b11
   } dcc_sel_t;

endpackage

// ### design/dcc_clock_control.sv
// dcc_clock_control: dual oscillator clock control with stop/wait handling.
// Assumes oscillator ticks arrive asynchronously as pins and the cpu strobes
// stop/wait and wake events synchronously to clk.
//
// Operation
// - slow source stop halts fast, clears six-bit counter
// - irq wake restarts fast, cpu runs on slow
// - clearing enable stops fast, presets chain 0x0078
// - reenable restarts fast, ready after 8072 counts
// - enable clear plus stop: wake keeps fast off
// - stop halts fast and cpu/periph clocks, clears fast ready
// - stop exits on reset, irq, key, spi, tick
// - fast source stop resumes after counter overflow
// - wait halts only cpu, exits on interrupt
// - slow oscillator runs always, feeds system clock
// - power-on divider preset 0x0078, overflow releases reset
// - slow/2 system tick, slow/64 and /128 lcd
// - fast ready cleared by power-on or disable
// - slow ready set after 16264 slow clocks
// - bits five and four read zero
// - select 00 fast/2, 01 /4, 10 /64, 11 slow/2
// - enable set by reset, clearing drops ready
// - option map select cleared on reset
// - mask option status register is readable
// - stabilisation counter on fast/128, divider taps 2/4/64
`include "dcc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module dcc_clock_control #(
   parameter logic [7:0] MASK_OPT_VAL = 8'h00
) (
   // clock, reset, enable
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            clk_en,
   input  wire logic            pwr_on_det,
   // oscillator pins
   input  wire logic            fast_osc_in,
   input  wire logic            slow_osc_in,
   output logic                 fast_osc_run_q,
   // cpu events
   input  wire logic            stop_req,
   input  wire logic            wait_req,
   input  wire logic            ext_irq,
   input  wire logic            key_wakeup_interrupt,
   input  wire logic            spi_slave_wake,
   input  wire logic            periodic_tick_interrupt,
   input  wire logic            any_interrupt,
   // register port
   input  wire logic [3:0]      reg_addr,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [7:0]      reg_rdata_q,
   // clock outputs
   output logic                 cpu_clk_en_q,
   output logic                 periph_clk_en_q,
   output logic                 lcd_tick64_q,
   output logic                 lcd_tick128_q,
   output logic                 por_active_q,
   output logic                 option_map_select_q,
   output dcc_pkg::dcc_mode_t   mode_q
);
   import dcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detect
   logic [2:0] fast_sync_q;
   logic [2:0] slow_sync_q;
   logic       fast_tick;
   logic       slow_tick;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fast_sync_q <= 3'h0;
         slow_sync_q <= 3'h0;
      end else if (clk_en) begin
         fast_sync_q <= {fast_sync_q[1:0], fast_osc_in};
         slow_sync_q <= {slow_sync_q[1:0], slow_osc_in};
      end
   end

   // edge detect reads stage two and three only
   assign fast_tick = fast_sync_q[1] & ~fast_sync_q[2] & fast_osc_run_q;
   assign slow_tick = slow_sync_q[1] & ~slow_sync_q[2];

   ////////////////////////////////////////////////////////////////////////////
   // control register
   dcc_sel_t sel_q;
   logic     fosc_en_q;
   logic     fast_rdy_q;
   logic     slow_rdy_q;
   logic     wr_ctrl;
   logic     fosc_clear;
   logic     fosc_set;

   assign wr_ctrl    = reg_wr && (reg_addr == `DCC_ADDR_CTRL);
   assign fosc_clear = wr_ctrl && fosc_en_q && !reg_wdata[`DCC_BIT_FOSC_EN];
   assign fosc_set   = wr_ctrl && !fosc_en_q && reg_wdata[`DCC_BIT_FOSC_EN];

   // software is trusted to pick only ready sources and keep enable on fast
   always_ff @(posedge clk) begin
      if (!rst_n || pwr_on_det) begin
         sel_q               <= DCC_SEL_FAST2;
         fosc_en_q           <= 1'b1;
         option_map_select_q <= 1'b0;
      end else if (clk_en && wr_ctrl) begin
         sel_q               <= dcc_sel_t'(reg_wdata[`DCC_BIT_SEL_HI:`DCC_BIT_SEL_LO]);
         fosc_en_q           <= reg_wdata[`DCC_BIT_FOSC_EN];
         option_map_select_q <= reg_wdata[`DCC_BIT_OPT_MAP];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode machine
   logic stop_wake;
   assign stop_wake = ext_irq | key_wakeup_interrupt | spi_slave_wake
                    | periodic_tick_interrupt;

   always_ff @(posedge clk) begin
      if (!rst_n || pwr_on_det) begin
         mode_q <= DCC_RUN; // reset also leaves stop
      end else if (clk_en) begin
         unique case (mode_q)
            DCC_RUN: begin
               if (stop_req) begin
                  mode_q <= DCC_STOP;
               end else if (wait_req) begin
                  mode_q <= DCC_WAIT;
               end
            end
            DCC_WAIT: begin
               if (any_interrupt) begin
                  mode_q <= DCC_RUN;
               end
            end
            DCC_STOP: begin
               if (stop_wake) begin
                  mode_q <= DCC_RUN;
               end
            end
            default: begin
               mode_q <= DCC_RUN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fast oscillator run and stabilisation chain
   logic [12:0] fast_chain_q; // [12:7] stabilisation counter, [6:0] divider
   logic        fast_ovf;
   logic        stop_entry;

   assign stop_entry = (mode_q == DCC_RUN) && stop_req;
   assign fast_ovf   = fast_tick && (fast_chain_q == 13'h1FFF);

   always_ff @(posedge clk) begin
      if (!rst_n || pwr_on_det) begin
         fast_osc_run_q <= 1'b1;
      end else if (clk_en) begin
         // disabled or stopped means no fast oscillation
         // a write that sets the enable restarts the crystal one cycle early
         fast_osc_run_q <= (fosc_en_q || fosc_set) && !fosc_clear && !stop_entry
                           && (mode_q != DCC_STOP || stop_wake);
      end
   end

   always_ff @(posedge clk) begin
      if (pwr_on_det) begin
         fast_chain_q <= `DCC_PRESET_FAST;
      end else if (clk_en) begin
         if (fosc_clear || !fosc_en_q) begin
            fast_chain_q <= `DCC_PRESET_FAST;
         end else if (stop_entry) begin
            fast_chain_q <= {6'h00, fast_chain_q[6:0]}; // divider kept
         end else if (fast_tick) begin
            fast_chain_q <= fast_chain_q + 13'h0001; // counter on fast/128
         end
      end
   end

   // reset leaves the ready flags alone; set wins over clear
   always_ff @(posedge clk) begin
      if (pwr_on_det) begin
         fast_rdy_q <= 1'b0;
      end else if (clk_en) begin
         if (fast_ovf) begin
            fast_rdy_q <= 1'b1;
         end else if (fosc_clear || stop_entry) begin
            fast_rdy_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power-on divider on the slow oscillator
   logic [13:0] pod_q;
   logic        pod_ovf;
   assign pod_ovf = slow_tick && (pod_q == 14'h3FFF);

   always_ff @(posedge clk) begin
      if (pwr_on_det) begin
         pod_q        <= `DCC_PRESET_POD;
         slow_rdy_q   <= 1'b0;
         por_active_q <= 1'b1;
      end else if (clk_en) begin
         if (slow_tick) begin
            pod_q <= pod_q + 14'h0001;
         end
         if (pod_ovf) begin
            slow_rdy_q   <= 1'b1; // never cleared while powered
            por_active_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // system and lcd ticks
   logic sys_tick;
   logic cpu_ok;

   always_comb begin
      unique case (sel_q)
         DCC_SEL_FAST2:  sys_tick = fast_tick && (fast_chain_q[0] == 1'b1);
         DCC_SEL_FAST4:  sys_tick = fast_tick && (fast_chain_q[1:0] == 2'h3);
         DCC_SEL_FAST64: sys_tick = fast_tick && (fast_chain_q[5:0] == 6'h3F);
         DCC_SEL_SLOW2:  sys_tick = slow_tick && (pod_q[0] == 1'b1);
      endcase
   end

   // fast source waits for overflow after stop or power-on
   assign cpu_ok = !por_active_q && ((sel_q == DCC_SEL_SLOW2) || fast_rdy_q);

   always_ff @(posedge clk) begin
      if (!rst_n || pwr_on_det) begin
         cpu_clk_en_q    <= 1'b0;
         periph_clk_en_q <= 1'b0;
         lcd_tick64_q    <= 1'b0;
         lcd_tick128_q   <= 1'b0;
      end else if (clk_en) begin
         cpu_clk_en_q    <= sys_tick && cpu_ok && (mode_q == DCC_RUN);
         periph_clk_en_q <= sys_tick && cpu_ok && (mode_q != DCC_STOP);
         lcd_tick64_q    <= slow_tick && ((pod_q & `DCC_LCD64_MASK) == `DCC_LCD64_MASK);
         lcd_tick128_q   <= slow_tick && ((pod_q & `DCC_LCD128_MASK) == `DCC_LCD128_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata_q <= 8'h00;
      end else if (clk_en) begin
         reg_rdata_q <= 8'h00; // unmapped and idle read as zero
         if (reg_rd && reg_addr == `DCC_ADDR_CTRL) begin
            reg_rdata_q <= {fast_rdy_q, slow_rdy_q, 2'b00, sel_q, fosc_en_q,
                            option_map_select_q};
         end else if (reg_rd && reg_addr == `DCC_ADDR_MASK_OPTION_STATUS) begin
            reg_rdata_q <= MASK_OPT_VAL;
         end
      end
   end

endmodule
`default_nettype wire

// ### dv/dcc_osc_model.sv
// dcc_osc_model: both crystals as seen at the oscillator pins.
// assumes the pins are synchronised inside the block.
`timescale 1ns/1ps
`default_nettype none
module dcc_osc_model (
   // clock and control
   input  wire logic clk,
   input  wire logic fast_run,
   // oscillator pins
   output var  logic fast_osc_in,
   output var  logic slow_osc_in
);
   initial begin
      fast_osc_in = 1'b0;
      slow_osc_in = 1'b0;
   end
   // slow crystal never stops while powered
   always @(posedge clk) begin
      slow_osc_in <= ~slow_osc_in;
   end
   // fast crystal stands low while disabled
   always @(posedge clk) begin
      fast_osc_in <= fast_run ? ~fast_osc_in : 1'b0;
   end
endmodule
`default_nettype wire

// ### dv/dcc_monitor.sv
// dcc_monitor: port checks on the clock control.
// assumes one clk domain; rst_n and pwr_on_det both reset.
`timescale 1ns/1ps
`default_nettype none
module dcc_monitor (
   // watched ports
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               pwr_on_det,
   input wire logic               stop_req,
   input wire logic               ext_irq,
   input wire logic               key_wakeup_interrupt,
   input wire logic               spi_slave_wake,
   input wire logic               periodic_tick_interrupt,
   input wire logic               any_interrupt,
   input wire logic [3:0]         reg_addr,
   input wire logic [7:0]         reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [7:0]         reg_rdata_q,
   input wire logic               fast_osc_run_q,
   input wire logic               cpu_clk_en_q,
   input wire logic               periph_clk_en_q,
   input wire logic               lcd_tick64_q,
   input wire logic               lcd_tick128_q,
   input wire logic               option_map_select_q,
   input wire dcc_pkg::dcc_mode_t mode_q
);
   import dcc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n || pwr_on_det);
   property p_stop; mode_q == DCC_RUN && stop_req |=> mode_q == DCC_STOP; endproperty
   a_stop: assert property (p_stop) else $error("stop entry missed");
   property p_wake; mode_q == DCC_STOP && (ext_irq || key_wakeup_interrupt || spi_slave_wake
      || periodic_tick_interrupt) |=> mode_q == DCC_RUN; endproperty
   a_wake: assert property (p_wake) else $error("stop exit missed");
   property p_halt; mode_q == DCC_STOP && $past(mode_q) == DCC_STOP
      |-> !fast_osc_run_q && !cpu_clk_en_q && !periph_clk_en_q; endproperty
   a_halt: assert property (p_halt) else $error("clock running in stop");
   property p_wexit; mode_q == DCC_WAIT && any_interrupt |=> mode_q == DCC_RUN; endproperty
   a_wexit: assert property (p_wexit) else $error("wait exit missed");
   property p_wcpu; mode_q == DCC_WAIT && $past(mode_q) == DCC_WAIT |-> !cpu_clk_en_q;
   endproperty
   a_wcpu: assert property (p_wcpu) else $error("cpu clock in wait");
   property p_enclr; reg_wr && reg_addr == 4'h0 && !reg_wdata[1] |=> !fast_osc_run_q;
   endproperty
   a_enclr: assert property (p_enclr) else $error("fast osc kept running");
   property p_option_map_select; reg_wr && reg_addr == 4'h0
      |=> option_map_select_q == $past(reg_wdata[0]); endproperty
   a_option_map_select: assert property (p_option_map_select) else $error("option map not written");
   property p_rsvd; reg_rd && reg_addr == 4'h0 |=> reg_rdata_q[5:4] == 2'b00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_lcd; lcd_tick64_q |=> !lcd_tick64_q [*8]; endproperty
   a_lcd: assert property (p_lcd) else $error("lcd tick too close");
   property p_lcd128; lcd_tick128_q |=> !lcd_tick128_q [*8]; endproperty
   a_lcd128: assert property (p_lcd128) else $error("lcd slow tick too close");
   property p_lcdnest; lcd_tick128_q |-> lcd_tick64_q; endproperty
   a_lcdnest: assert property (p_lcdnest) else $error("lcd ticks not nested");
   property p_rst; disable iff (1'b0) !rst_n
      |=> fast_osc_run_q && !option_map_select_q && mode_q == DCC_RUN; endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
`default_nettype wire

// ### dv/dcc_clock_control_test.sv
// dcc_clock_control_test: self-checking bench of the clock control.
// assumes dcc_osc_model drives both oscillator pins.
`timescale 1ns/1ps
`default_nettype none
module dcc_clock_control_test;
   import dcc_pkg::*;
   logic       clk = 1'b0, rst_n = 1'b0, pwr_on_det = 1'b1;
   logic       stop_req = 1'b0, wait_req = 1'b0, any_interrupt = 1'b0;
   logic [3:0] wake = 4'h0, reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, rdata = 8'h00, w;
   logic       reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] lfsr = 16'hEDCE;
   wire logic  fast_in, slow_in, run, cpu_en, por, option_map_select;
   wire logic [7:0] rdq;
   dcc_mode_t  mode;
   int         failures = 0, checked = 0, n;
   always #5 clk = ~clk;
   dcc_osc_model u_osc (.clk(clk), .fast_run(run), .fast_osc_in(fast_in), .slow_osc_in(slow_in));
   dcc_clock_control #(.MASK_OPT_VAL(8'h5A)) DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
      .pwr_on_det(pwr_on_det), .fast_osc_in(fast_in), .slow_osc_in(slow_in),
      .fast_osc_run_q(run), .stop_req(stop_req), .wait_req(wait_req), .ext_irq(wake[0]),
      .key_wakeup_interrupt(wake[1]), .spi_slave_wake(wake[2]),
      .periodic_tick_interrupt(wake[3]), .any_interrupt(any_interrupt), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdq),
      .cpu_clk_en_q(cpu_en), .periph_clk_en_q(), .lcd_tick64_q(), .lcd_tick128_q(),
      .por_active_q(por), .option_map_select_q(option_map_select), .mode_q(mode));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] ctrl(input logic [1:0] rdy, input logic [7:0] v);
      return {rdy, 2'b00, v[3:0]};
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string nm);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rdata = rdq;
      @(posedge clk);
      if (nm != "") chk(nm, rdata, exp);
   endtask
   task automatic wait_rdy(input int lim);
      n = 0; rdata = 8'h00;
      while (rdata[7] !== 1'b1 && n < lim) begin
         rdc(4'h0, 8'h00, ""); n++;
      end
   endtask
   task automatic stop_wake(input int src, input logic exp_run);
      stop_req <= 1'b1; @(posedge clk); stop_req <= 1'b0; #1;
      chk("stop_mode", {6'h0, mode}, {6'h0, DCC_STOP});
      chk("stop_fast", {7'h0, run}, 8'h00);
      repeat (3) @(posedge clk);
      wake <= 4'h1 << src; @(posedge clk); wake <= 4'h0; #1;
      chk("wake_mode", {6'h0, mode}, {6'h0, DCC_RUN});
      chk("wake_fast", {7'h0, run}, {7'h0, exp_run});
   endtask
   task automatic close_out;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge clk);
      failures++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1; pwr_on_det <= 1'b0;
      @(posedge clk);
      rdc(4'h0, 8'h02, "ctrl_por");
      chk("por_active", {7'h0, por}, 8'h01);
      n = 0;
      while (por === 1'b1 && n < 40000) begin @(posedge clk); n++; end
      rdc(4'h0, 8'hC2, "ctrl_up");
      rdc(4'h1, 8'h5A, "mask_opt");
      wr(4'hF, 8'hFF);
      rdc(4'hF, 8'h00, "unmapped");
      for (int i = 0; i < 6; i++) begin
         lfsr = nx(lfsr);
         w = (i == 0) ? 8'hFF : {lfsr[7:2], 1'b1, lfsr[0]};
         wr(4'h0, w);
         rdc(4'h0, ctrl(2'b11, w), "ctrl_rand");
         chk("opt_map", {7'h0, option_map_select}, {7'h0, w[0]});
      end
      wr(4'h0, 8'h0E); wr(4'h0, 8'h0C);
      rdc(4'h0, 8'h4C, "ctrl_off");
      chk("fast_off", {7'h0, run}, 8'h00);
      wr(4'h0, 8'h0E);
      repeat (16000) @(posedge clk);
      rdc(4'h0, 8'h4E, "ctrl_early");
      wait_rdy(200);
      rdc(4'h0, 8'hCE, "ctrl_ready");
      for (int i = 0; i < 4; i++) begin
         stop_wake(i, 1'b1);
         rdc(4'h0, 8'h4E, "ctrl_stop");
      end
      repeat (15900) @(posedge clk);
      rdc(4'h0, 8'h4E, "restart_early");
      wait_rdy(400);
      rdc(4'h0, 8'hCE, "restart_ready");
      wr(4'h0, 8'h0C);
      stop_wake(0, 1'b0);
      rdc(4'h0, 8'h4C, "ctrl_off_stop");
      wait_req <= 1'b1; @(posedge clk); wait_req <= 1'b0; #1;
      chk("wait_mode", {6'h0, mode}, {6'h0, DCC_WAIT});
      wake <= 4'h1; @(posedge clk); wake <= 4'h0; #1;
      chk("wait_hold", {6'h0, mode}, {6'h0, DCC_WAIT});
      any_interrupt <= 1'b1; @(posedge clk); any_interrupt <= 1'b0; #1;
      chk("wait_exit", {6'h0, mode}, {6'h0, DCC_RUN});
      wr(4'h0, 8'h0D);
      rst_n <= 1'b0; @(posedge clk); rst_n <= 1'b1; @(posedge clk);
      rdc(4'h0, 8'h42, "ctrl_rst");
      stop_wake(0, 1'b1);
      n = 0;
      while (cpu_en !== 1'b1 && n < 17000) begin @(posedge clk); n++; end
      chk("cpu_resume", {7'h0, n >= 16000 && n < 17000}, 8'h01);
      rdc(4'h0, 8'hC2, "ctrl_resume");
      close_out();
   end
endmodule
bind dcc_clock_control dcc_monitor u_mon (.clk(clk), .rst_n(rst_n), .pwr_on_det(pwr_on_det),
   .stop_req(stop_req), .ext_irq(ext_irq), .key_wakeup_interrupt(key_wakeup_interrupt),
   .spi_slave_wake(spi_slave_wake), .periodic_tick_interrupt(periodic_tick_interrupt),
   .any_interrupt(any_interrupt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .fast_osc_run_q(fast_osc_run_q), .cpu_clk_en_q(cpu_clk_en_q),
   .periph_clk_en_q(periph_clk_en_q), .lcd_tick64_q(lcd_tick64_q),
   .lcd_tick128_q(lcd_tick128_q),
   .option_map_select_q(option_map_select_q), .mode_q(mode_q));
`default_nettype wire
